// ### hw/cis_pkg.sv
// shared constants, encodings and types of the instruction execute block
package cis_pkg;
   localparam int DW     = 24;
   localparam int PCW    = 12;
   localparam int PTRW   = 8;
   localparam int MEM_AW = 6;
   localparam int CFGW   = 4;
   localparam int CNTW   = 5;
   localparam int BYTW   = 3;

   // opcode encodings
   typedef enum logic [7:0] {
      OP_CLRWDT = 8'h01,
      OP_CMP    = 8'h02,
      OP_NEG    = 8'h03,
      OP_DECR   = 8'h04,
      OP_DECPTR = 8'h05,
      OP_SEG    = 8'h06,
      OP_FDIV   = 8'h07,
      OP_DIVMOD = 8'h08,
      OP_XOR    = 8'h09,
      OP_XNOR   = 8'h0a,
      OP_CFGWR  = 8'h0b,
      OP_EERD   = 8'h0c,
      OP_FLAGT  = 8'h0d,
      OP_JMP    = 8'h0e,
      OP_BITC   = 8'h0f,
      OP_BITS   = 8'h10
   } cis_op_t;

   // command register layout
   typedef struct packed {
      logic [12:0] rsvd;
      logic        absolute;
      logic        use_const;
      logic [4:0]  bit_idx;
      logic [1:0]  src;
      logic [1:0]  dst;
      logic [7:0]  op;
   } cis_cmd_t;

   typedef struct packed {
      logic c;
      logic o;
      logic s;
      logic z;
   } cis_flags_t;

   // register byte offsets
   localparam logic [7:0] OFF_CMD    = 8'h00;
   localparam logic [7:0] OFF_CONST  = 8'h04;
   localparam logic [7:0] OFF_ACC0   = 8'h08;
   localparam logic [7:0] OFF_ACC1   = 8'h0c;
   localparam logic [7:0] OFF_ACC2   = 8'h10;
   localparam logic [7:0] OFF_ACC3   = 8'h14;
   localparam logic [7:0] OFF_FLAGS  = 8'h18;
   localparam logic [7:0] OFF_PC     = 8'h1c;
   localparam logic [7:0] OFF_RAMPTR = 8'h20;
   localparam logic [7:0] OFF_STATUS = 8'h24;

   localparam int ST_BUSY  = 0;
   localparam int ST_ERR   = 1;
   localparam int ST_STACK = 2;
   localparam int ST_CFG   = 4;

   localparam logic [4:0] BIT_MAX     = 5'd23;
   localparam logic [1:0] DIVMOD_SMAX = 2'd2;
   localparam logic [3:0] SEG_MAX     = 4'd9;
   localparam int         REL_DW      = 8;

   // seven-segment patterns, digit 0 in the low byte
   localparam logic [9:0][7:0] SEG_TABLE = {8'h6f, 8'h7f, 8'h07, 8'h7d, 8'h6d,
                                            8'h66, 8'h4f, 8'h3b, 8'h06, 8'h3f};

   // cycle counts
   localparam logic [CNTW-1:0] CYC_ONE    = 5'd1;
   localparam logic [CNTW-1:0] CYC_NEG    = 5'd2;
   localparam logic [CNTW-1:0] CYC_THREE  = 5'd3;
   localparam logic [CNTW-1:0] CYC_FOUR   = 5'd4;
   localparam logic [CNTW-1:0] CYC_SIX    = 5'd6;
   localparam logic [CNTW-1:0] CYC_FDIV   = 5'd20;
   localparam logic [CNTW-1:0] CYC_DIVMOD = 5'd24;

   // instruction lengths in bytes
   localparam logic [BYTW-1:0] BYT_ONE   = 3'd1;
   localparam logic [BYTW-1:0] BYT_TWO   = 3'd2;
   localparam logic [BYTW-1:0] BYT_THREE = 3'd3;
   localparam logic [BYTW-1:0] BYT_FOUR  = 3'd4;
   localparam logic [BYTW-1:0] BYT_FIVE  = 3'd5;
endpackage : cis_pkg

// ### hw/cis_mem_if.sv
// port group between the execute core and the program memory
`timescale 1ns/100ps
`default_nettype none
interface cis_mem_if;
   import cis_pkg::*;
   logic              we;
   logic [MEM_AW-1:0] waddr;
   logic [DW-1:0]     wdata;
   logic [MEM_AW-1:0] raddr;
   logic [DW-1:0]     rdata;
   modport ctrl (output we, output waddr, output wdata, output raddr, input rdata);
   modport mem  (input we, input waddr, input wdata, input raddr, output rdata);
endinterface : cis_mem_if
`default_nettype wire

// ### hw/cis_eeprom_mem.sv
// program memory with registered read data
`timescale 1ns/100ps
`default_nettype none
module cis_eeprom_mem (
   input wire logic clk_sys_in,
   input wire logic rst_n_in,
   cis_mem_if.mem   mem_if
);
   import cis_pkg::*;
   logic [DW-1:0] store [2**MEM_AW];

   always_ff @(posedge clk_sys_in) begin
      if (mem_if.we) begin
         store[mem_if.waddr] <= mem_if.wdata;
      end
   end

   always_ff @(posedge clk_sys_in) begin
      if (!rst_n_in) begin
         mem_if.rdata <= '0;
      end else begin
         mem_if.rdata <= store[mem_if.raddr];
      end
   end
endmodule : cis_eeprom_mem
`default_nettype wire

// ### hw/cis_core.sv
// instruction execute core with AHB-Lite register access
// Functional notes
// - watchdog clear: two bytes, restart watchdog
// - compare: p2 minus p1 sets flags only
// - negate: inverse plus one, S Z
// - decrement accumulator with flags, pointer without
// - digit zero to nine becomes segment pattern
// - fraction divide: (p1 shl 24)/p2, S Z
// - signed divide: quotient p1, remainder p2
// - xor with accumulator or constant, S Z
// - xnor with accumulator or constant, S Z
// - config write fills next of 16 words
// - memory read at pointer, uses stack entry
// - flag test: S negative, Z nonzero
// - jump loads program counter, flags untouched
// - branch taken when selected bit clear
// - branch taken when selected bit set
// - relative target adds signed eight-bit displacement
// - absolute target carries twelve address bits
// - 24-bit two's complement, result to first
`timescale 1ns/100ps
`default_nettype none
module cis_core (
   // clock and reset
   input  wire logic        clk_sys_in,
   input  wire logic        rst_n_in,
   // AHB-Lite slave
   input  wire logic        hsel_in,
   input  wire logic [31:0] haddr_in,
   input  wire logic [1:0]  htrans_in,
   input  wire logic        hwrite_in,
   input  wire logic [2:0]  hsize_in,
   input  wire logic        hready_in,
   input  wire logic [31:0] hwdata_in,
   output var  logic [31:0] hrdata_out,
   output var  logic        hreadyout_out,
   output var  logic        hresp_out,
   // status
   output var  logic        wdog_clear_out,
   output var  logic        busy_out
);
   import cis_pkg::*;

   cis_mem_if mem_if ();

   cis_eeprom_mem u_mem (
      .clk_sys_in (clk_sys_in),
      .rst_n_in   (rst_n_in),
      .mem_if     (mem_if)
   );

   logic [DW-1:0]     acc [4];
   cis_flags_t        flags;
   logic [PCW-1:0]    pc;
   logic [PCW-1:0]    pc_stack;
   logic              stack_used;
   logic [PTRW-1:0]   ramptr;
   logic [CFGW-1:0]   cfg_ptr;
   logic              err;
   cis_cmd_t          cmd;
   logic [DW-1:0]     konst;
   logic              busy;
   logic [CNTW-1:0]   cnt;
   logic              fire;
   logic              wr_pend;
   logic [7:0]        wr_addr;
   logic              bus_wr;
   cis_cmd_t          new_cmd;
   logic [CNTW-1:0]   cycles;
   logic [BYTW-1:0]   bytes;
   logic [DW-1:0]     next_acc [4];
   cis_flags_t        next_flags;
   logic [PCW-1:0]    next_pc;
   logic [PTRW-1:0]   next_ptr;
   logic              next_err;
   logic [DW-1:0]     op_a;
   logic [DW-1:0]     op_b;
   logic [DW-1:0]     sub_x;
   logic [DW-1:0]     sub_y;
   logic [DW:0]       sub_r;
   logic [2*DW-1:0]   fdiv_q;
   logic [DW-1:0]     res;
   logic              sel_bit;

   assign fire    = busy && (cnt == '0);
   assign bus_wr  = wr_pend;
   assign new_cmd = cis_cmd_t'(hwdata_in);
   assign op_a    = acc[cmd.dst];
   assign op_b    = cmd.use_const ? konst : acc[cmd.src];
   assign sub_r   = {1'b0, sub_x} + {1'b0, ~sub_y} + {{DW{1'b0}}, 1'b1};
   assign fdiv_q  = 48'($signed({op_a, {DW{1'b0}}}) / $signed({{DW{op_b[DW-1]}}, op_b}));
   assign sel_bit = op_a[cmd.bit_idx];

   // memory side
   assign mem_if.we    = fire && (cmd.op == OP_CFGWR);
   assign mem_if.waddr = MEM_AW'(cfg_ptr);
   assign mem_if.wdata = konst;
   assign mem_if.raddr = ramptr[MEM_AW-1:0];

   // cost of the pending command word
   always_comb begin
      cycles = CYC_ONE;
      bytes  = BYT_ONE;
      case (new_cmd.op)
         OP_CLRWDT: begin bytes = BYT_TWO; end
         OP_CMP: begin
            cycles = new_cmd.use_const ? CYC_FOUR : CYC_ONE;
            bytes  = new_cmd.use_const ? BYT_FOUR : BYT_ONE;
         end
         OP_NEG: begin cycles = CYC_NEG; bytes = BYT_TWO; end
         OP_DECR, OP_DECPTR, OP_FLAGT: begin cycles = CYC_ONE; end
         OP_SEG: begin cycles = CYC_THREE; bytes = BYT_TWO; end
         OP_FDIV: begin cycles = CYC_FDIV; bytes = BYT_TWO; end
         OP_DIVMOD: begin cycles = CYC_DIVMOD; bytes = BYT_TWO; end
         OP_XOR, OP_XNOR: begin
            cycles = new_cmd.use_const ? CYC_SIX : CYC_THREE;
            bytes  = new_cmd.use_const ? BYT_FIVE : BYT_TWO;
         end
         OP_CFGWR: begin cycles = CYC_THREE; bytes = BYT_THREE; end
         OP_EERD: begin cycles = CYC_SIX; end
         OP_JMP: begin
            cycles = new_cmd.absolute ? CYC_FOUR : CYC_THREE;
            bytes  = new_cmd.absolute ? BYT_THREE : BYT_TWO;
         end
         OP_BITC, OP_BITS: begin cycles = CYC_FOUR; bytes = BYT_THREE; end
         default: begin cycles = CYC_ONE; end
      endcase
   end

   // result of the executing command
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         next_acc[i] = acc[i];
      end
      next_flags = flags;
      next_pc    = PCW'(pc + PCW'(bytes_run(cmd)));
      next_ptr   = ramptr;
      next_err   = 1'b0;
      sub_x      = op_a;
      sub_y      = {{(DW-1){1'b0}}, 1'b1};
      res        = op_a;
      case (cmd.op)
         OP_CMP: begin
            sub_x      = op_b;
            sub_y      = op_a;
            next_flags = arith_flags(sub_x, sub_y, sub_r);
         end
         OP_NEG: begin
            res               = DW'(~op_a + {{(DW-1){1'b0}}, 1'b1});
            next_acc[cmd.dst] = res;
            next_flags.s      = res[DW-1];
            next_flags.z      = (res != '0);
         end
         OP_DECR: begin
            next_acc[cmd.dst] = sub_r[DW-1:0];
            next_flags        = arith_flags(sub_x, sub_y, sub_r);
         end
         OP_DECPTR: begin next_ptr = PTRW'(ramptr - {{(PTRW-1){1'b0}}, 1'b1}); end
         OP_SEG: begin
            if (op_a <= DW'(SEG_MAX)) begin
               next_acc[cmd.dst] = DW'(SEG_TABLE[op_a[3:0]]);
            end else begin
               next_err = 1'b1;
            end
         end
         OP_FDIV, OP_DIVMOD: begin
            if (op_b == '0 || (cmd.op == OP_DIVMOD && cmd.src > DIVMOD_SMAX)) begin
               next_err = 1'b1;
            end else begin
               if (cmd.op == OP_FDIV) begin
                  res = fdiv_q[DW-1:0];
               end else begin
                  res               = DW'($signed(op_a) / $signed(op_b));
                  next_acc[cmd.src] = DW'($signed(op_a) % $signed(op_b));
               end
               next_acc[cmd.dst] = res;
               next_flags.s      = res[DW-1];
               next_flags.z      = (res != '0);
            end
         end
         OP_XOR, OP_XNOR: begin
            res               = (cmd.op == OP_XOR) ? (op_a ^ op_b) : ~(op_a ^ op_b);
            next_acc[cmd.dst] = res;
            next_flags.s      = res[DW-1];
            next_flags.z      = (res != '0);
         end
         OP_EERD: begin
            next_acc[cmd.dst] = mem_if.rdata;
            next_flags.s      = mem_if.rdata[DW-1];
            next_flags.z      = (mem_if.rdata != '0);
            next_pc           = PCW'(pc_stack + PCW'(BYT_ONE));
         end
         OP_FLAGT: begin
            next_flags.s = op_a[DW-1];
            next_flags.z = (op_a != '0);
         end
         OP_JMP: begin
            next_pc = cmd.absolute ? konst[PCW-1:0] :
                      PCW'(pc + {{(PCW-REL_DW){konst[REL_DW-1]}}, konst[REL_DW-1:0]});
         end
         OP_BITC, OP_BITS: begin
            if (cmd.bit_idx > BIT_MAX) begin
               next_err = 1'b1;
            end else if (sel_bit == (cmd.op == OP_BITS)) begin
               next_pc = konst[PCW-1:0];
            end
         end
         OP_CLRWDT, OP_CFGWR: begin end
         default: begin next_err = 1'b1; end
      endcase
   end

   function automatic logic [BYTW-1:0] bytes_run(input cis_cmd_t c);
      logic [BYTW-1:0] b;
      b = BYT_ONE;
      case (c.op)
         OP_CLRWDT, OP_NEG, OP_SEG, OP_FDIV, OP_DIVMOD: b = BYT_TWO;
         OP_CMP:            b = c.use_const ? BYT_FOUR : BYT_ONE;
         OP_XOR, OP_XNOR:   b = c.use_const ? BYT_FIVE : BYT_TWO;
         OP_CFGWR, OP_BITC, OP_BITS: b = BYT_THREE;
         OP_JMP:            b = c.absolute ? BYT_THREE : BYT_TWO;
         default:           b = BYT_ONE;
      endcase
      return b;
   endfunction

   // C is carry out of x + ~y + 1, O is signed overflow of x - y
   function automatic cis_flags_t arith_flags(input logic [DW-1:0] x,
                                              input logic [DW-1:0] y,
                                              input logic [DW:0]   r);
      cis_flags_t f;
      f.c = r[DW];
      f.o = (x[DW-1] != y[DW-1]) && (r[DW-1] != x[DW-1]);
      f.s = r[DW-1];
      f.z = (r[DW-1:0] != '0);
      return f;
   endfunction

   // bus slave: zero wait states, read data registered in the address phase
   always_ff @(posedge clk_sys_in) begin
      if (!rst_n_in) begin
         wr_pend       <= 1'b0;
         wr_addr       <= '0;
         hrdata_out    <= '0;
         hreadyout_out <= 1'b1;
         hresp_out     <= 1'b0;
      end else begin
         hreadyout_out <= 1'b1;
         hresp_out     <= 1'b0;
         wr_pend       <= hsel_in && hready_in && htrans_in[1] && hwrite_in;
         wr_addr       <= haddr_in[7:0];
         if (hsel_in && hready_in && htrans_in[1] && !hwrite_in) begin
            case (haddr_in[7:0])
               OFF_CMD:    hrdata_out <= 32'(cmd);
               OFF_CONST:  hrdata_out <= 32'(konst);
               OFF_ACC0:   hrdata_out <= 32'(acc[0]);
               OFF_ACC1:   hrdata_out <= 32'(acc[1]);
               OFF_ACC2:   hrdata_out <= 32'(acc[2]);
               OFF_ACC3:   hrdata_out <= 32'(acc[3]);
               OFF_FLAGS:  hrdata_out <= 32'(flags);
               OFF_PC:     hrdata_out <= 32'(pc);
               OFF_RAMPTR: hrdata_out <= 32'(ramptr);
               OFF_STATUS: hrdata_out <= 32'({cfg_ptr, 1'b0, stack_used, err, busy});
               default:    hrdata_out <= '0;
            endcase
         end
      end
   end

   // sequencing of one command
   always_ff @(posedge clk_sys_in) begin
      if (!rst_n_in) begin
         busy       <= 1'b0;
         cnt        <= '0;
         cmd        <= '0;
         stack_used <= 1'b0;
         pc_stack   <= '0;
      end else if (fire) begin
         busy       <= 1'b0;
         stack_used <= 1'b0;
      end else if (busy) begin
         cnt <= CNTW'(cnt - CYC_ONE);
      end else if (bus_wr && wr_addr == OFF_CMD) begin
         busy <= 1'b1;
         cnt  <= CNTW'(cycles - CYC_ONE);
         cmd  <= new_cmd;
         if (new_cmd.op == OP_EERD) begin
            stack_used <= 1'b1;
            pc_stack   <= pc;
         end
      end
   end

   // architectural state
   always_ff @(posedge clk_sys_in) begin
      if (!rst_n_in) begin
         for (int i = 0; i < 4; i++) begin
            acc[i] <= '0;
         end
         flags  <= '0;
         pc     <= '0;
         ramptr <= '0;
         konst  <= '0;
      end else if (fire) begin
         for (int i = 0; i < 4; i++) begin
            acc[i] <= next_acc[i];
         end
         flags  <= next_flags;
         pc     <= next_pc;
         ramptr <= next_ptr;
      end else if (bus_wr && !busy) begin
         case (wr_addr)
            OFF_CONST:  konst  <= hwdata_in[DW-1:0];
            OFF_ACC0:   acc[0] <= hwdata_in[DW-1:0];
            OFF_ACC1:   acc[1] <= hwdata_in[DW-1:0];
            OFF_ACC2:   acc[2] <= hwdata_in[DW-1:0];
            OFF_ACC3:   acc[3] <= hwdata_in[DW-1:0];
            OFF_PC:     pc     <= hwdata_in[PCW-1:0];
            OFF_RAMPTR: ramptr <= hwdata_in[PTRW-1:0];
            default: begin end
         endcase
      end
   end

   // config pointer, sticky error (set wins over clear), watchdog pulse
   always_ff @(posedge clk_sys_in) begin
      if (!rst_n_in) begin
         cfg_ptr        <= '0;
         err            <= 1'b0;
         wdog_clear_out <= 1'b0;
         busy_out       <= 1'b0;
      end else begin
         busy_out       <= busy;
         wdog_clear_out <= fire && (cmd.op == OP_CLRWDT);
         if (fire && cmd.op == OP_CFGWR) begin
            cfg_ptr <= CFGW'(cfg_ptr + {{(CFGW-1){1'b0}}, 1'b1});
         end
         if (fire && next_err) begin
            err <= 1'b1;
         end else if (bus_wr && wr_addr == OFF_STATUS && hwdata_in[ST_ERR]) begin
            err <= 1'b0;
         end
      end
   end

   default clocking cb @(posedge clk_sys_in); endclocking
   default disable iff (!rst_n_in);

   sequence s_start_xorc;
      $rose(busy) && cmd.op == OP_XOR && cmd.use_const;
   endsequence
   // nineteen counting cycles after the start, commit on the twentieth
   sequence s_run_fdiv;
      (busy && !fire)[*8] ##1 (busy && !fire)[*8] ##1 (busy && !fire)[*3] ##1 fire;
   endsequence

   a_cmp_regs_kept: assert property (fire && cmd.op == OP_CMP |=>
      acc[0] == $past(acc[0]) && acc[1] == $past(acc[1]) && acc[2] == $past(acc[2])
      && acc[3] == $past(acc[3]))
      else $error("compare altered an accumulator");
   a_xor_const_len: assert property (s_start_xorc |-> (busy && !fire)[*5] ##1 fire)
      else $error("xor with constant not six cycles");
   a_fdiv_len: assert property ($rose(busy) && cmd.op == OP_FDIV |-> s_run_fdiv)
      else $error("fraction divide not twenty cycles");
   a_neg_value: assert property (fire && cmd.op == OP_NEG |=>
      acc[$past(cmd.dst)] == DW'(~$past(op_a) + 24'h000001))
      else $error("negate result wrong");
   a_decptr_flags: assert property (fire && cmd.op == OP_DECPTR |=>
      ramptr == PTRW'($past(ramptr) - 8'h01) && $stable(flags))
      else $error("pointer decrement wrong");
   a_seg_five: assert property (fire && cmd.op == OP_SEG && op_a == 24'h000005 |=>
      acc[$past(cmd.dst)] == 24'h00006d)
      else $error("segment pattern for five wrong");
   a_bitc_taken: assert property (fire && cmd.op == OP_BITC && cmd.bit_idx <= BIT_MAX
      && !sel_bit |=> pc == $past(konst[PCW-1:0]))
      else $error("bit clear branch not taken");
   a_bits_flags: assert property (fire && cmd.op == OP_BITS |=> $stable(flags))
      else $error("bit set branch changed flags");
   a_flagt_z: assert property (fire && cmd.op == OP_FLAGT |=>
      flags.z == ($past(op_a) != 24'h000000) && flags.s == $past(op_a[DW-1]))
      else $error("flag test wrong");
   a_wdog_pulse: assert property (fire && cmd.op == OP_CLRWDT |=>
      wdog_clear_out ##1 !wdog_clear_out)
      else $error("watchdog clear pulse wrong");
endmodule : cis_core
`default_nettype wire

// ### verification/cis_ahb_host.sv
// bus master model that reaches the execute core's registers
`timescale 1ns/100ps
`default_nettype none
module cis_ahb_host (
   // clock
   input  wire logic        clk_in,
   // bus
   input  wire logic        hready_in,
   input  wire logic [31:0] hrdata_in,
   output var  logic [31:0] haddr_out,
   output var  logic [1:0]  htrans_out,
   output var  logic        hwrite_out,
   output var  logic [31:0] hwdata_out
);
   initial begin
      haddr_out  = 32'h0;
      htrans_out = 2'h0;
      hwrite_out = 1'b0;
      hwdata_out = 32'h0;
   end

   // one single word transfer, entered just after a rising edge
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q);
      haddr_out  <= {24'h0, a};
      htrans_out <= 2'h2;
      hwrite_out <= w;
      do @(posedge clk_in); while (hready_in !== 1'b1);
      htrans_out <= 2'h0;
      // a read leaves no stale value on the write data
      hwdata_out <= w ? d : ~hwdata_out;
      do @(posedge clk_in); while (hready_in !== 1'b1);
      q = hrdata_in;
   endtask
endmodule // cis_ahb_host
`default_nettype wire

// ### verification/cpu_instruction_semantics_tb.sv
// self-checking bench for the instruction execute core
`timescale 1ns/100ps
`default_nettype none
module cpu_instruction_semantics_tb;
   import cis_pkg::*;
   logic             clk_sys_in, rst_n_in, hrdy, hresp, wdog, busy, hwrite;
   logic [31:0]      haddr, hwdata, hrdata, q;
   logic [1:0]       htrans;
   logic [7:0]       nw, ew;
   int               n_mismatch, checked, nb;
   logic [DW-1:0]    acc [4];
   logic [DW-1:0]    mem [64];
   logic [7:0]       seg [10] = '{8'h3f, 8'h06, 8'h3b, 8'h4f, 8'h66,
                                  8'h6d, 8'h7d, 8'h07, 8'h7f, 8'h6f};
   cis_flags_t       fl;
   logic [PCW-1:0]   pc;
   logic [PTRW-1:0]  ptr;
   logic [3:0]       cfg;

   cis_core cis_core_i (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .hsel_in(1'b1),
      .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2),
      .hready_in(hrdy), .hwdata_in(hwdata), .hrdata_out(hrdata), .hreadyout_out(hrdy),
      .hresp_out(hresp), .wdog_clear_out(wdog), .busy_out(busy));
   cis_ahb_host cis_ahb_host_i (.clk_in(clk_sys_in), .hready_in(hrdy), .hrdata_in(hrdata),
      .haddr_out(haddr), .htrans_out(htrans), .hwrite_out(hwrite), .hwdata_out(hwdata));

   initial begin
      clk_sys_in = 1'b0;
      forever #50 clk_sys_in = ~clk_sys_in;
   end

   always @(posedge clk_sys_in) begin
      if (busy === 1'b1) nb <= nb + 1;
      if (wdog === 1'b1) nw <= nw + 8'h1;
   end

   task automatic print_verdict();
      $display("checks %0d mismatches %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         n_mismatch++;
         $display("Error %s expected %h seen %h", nm, exp, got);
      end
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      cis_ahb_host_i.xfer(1'b0, a, 32'h0, d);
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] dummy;
      cis_ahb_host_i.xfer(1'b1, a, d, dummy);
   endtask

   task automatic wa(input int i, input logic [DW-1:0] v);
      wr(OFF_ACC0 + 8'(4 * i), {8'h0, v});
      acc[i] = v;
   endtask

   function automatic cis_flags_t fsub(input logic [DW-1:0] x, input logic [DW-1:0] y);
      logic [DW:0] r;
      r = {1'b0, x} + {1'b0, ~y} + 25'h1;
      return '{c: r[DW], o: (x[DW-1] != y[DW-1]) && (r[DW-1] != x[DW-1]),
               s: r[DW-1], z: |r[DW-1:0]};
   endfunction

   function automatic cis_flags_t fsz(input logic [DW-1:0] v);
      return '{c: fl.c, o: fl.o, s: v[DW-1], z: |v};
   endfunction

   task automatic cmp_all();
      for (int i = 0; i < 4; i++) begin
         rd(OFF_ACC0 + 8'(4 * i), q);
         chk("acc", q, {8'h0, acc[i]});
      end
      rd(OFF_FLAGS, q);
      chk("flags", q, {28'h0, fl});
      rd(OFF_PC, q);
      chk("pc", q, {20'h0, pc});
      rd(OFF_RAMPTR, q);
      chk("ptr", q, {24'h0, ptr});
   endtask

   // m holds {write while busy, absolute form, constant operand}
   task automatic run(input logic [7:0] op, input logic [1:0] d, input logic [1:0] s,
                      input logic [4:0] b, input logic [2:0] m, input logic [23:0] k);
      cis_cmd_t              c;
      logic [DW-1:0]         x, y, r;
      logic signed [2*DW-1:0] fq;
      logic signed [DW-1:0]  dq, rm;
      logic [PCW-1:0]        rel;
      logic [7:0]            n, by;
      logic                  sz;
      x = acc[d];
      y = m[0] ? k : acc[s];
      fq = $signed({x, 24'h0}) / $signed({{24{y[DW-1]}}, y});
      dq = $signed(x) / $signed(y);
      rm = $signed(x) % $signed(y);
      rel = pc + {{4{k[7]}}, k[7:0]};
      {r, sz, n, by} = {x, 1'b0, 16'h0101};
      c = '{rsvd: 13'h0, absolute: m[1], use_const: m[0], bit_idx: b, src: s, dst: d, op: op};
      wr(OFF_CONST, {8'h0, k});
      nb = 0;
      wr(OFF_CMD, 32'(c));
      if (m[2]) wr(OFF_ACC3, 32'h5a5a5a);
      if (op == OP_EERD) begin
         rd(OFF_STATUS, q);
         chk("stack", q & 32'h5, 32'h5);
      end
      case (op)
         OP_CLRWDT: {ew, by} = {ew + 8'h1, 8'd2};
         OP_CMP: {fl, n, by} = {fsub(y, x), m[0] ? 16'h0404 : 16'h0101};
         OP_NEG: {r, sz, n, by} = {~x + 24'h1, 1'b1, 16'h0202};
         OP_DECR: {r, fl} = {x - 24'h1, fsub(x, 24'h1)};
         OP_DECPTR: ptr = ptr - 8'h1;
         OP_SEG: {r, n, by} = {16'h0, seg[x], 16'h0302};
         OP_FDIV: {r, sz, n, by} = {fq[DW-1:0], 1'b1, 16'h1402};
         OP_DIVMOD: {r, sz, n, by} = {dq, 1'b1, 16'h1802};
         OP_XOR: {r, sz, n, by} = {x ^ y, 1'b1, m[0] ? 16'h0605 : 16'h0302};
         OP_XNOR: {r, sz, n, by} = {x ~^ y, 1'b1, m[0] ? 16'h0605 : 16'h0302};
         OP_CFGWR: {mem[cfg], cfg, n, by} = {k, cfg + 4'h1, 16'h0303};
         OP_EERD: {r, sz, n} = {mem[ptr[5:0]], 1'b1, 8'd6};
         OP_FLAGT: sz = 1'b1;
         OP_JMP: {pc, n, by} = {m[1] ? k[11:0] : rel, m[1] ? 16'h0400 : 16'h0300};
         OP_BITC: {pc, n, by} = {x[b] ? pc : k[11:0], 8'd4, x[b] ? 8'd3 : 8'd0};
         OP_BITS: {pc, n, by} = {x[b] ? k[11:0] : pc, 8'd4, x[b] ? 8'd0 : 8'd3};
         default: sz = 1'b0;
      endcase
      if (sz) fl = fsz(r);
      // with one register named twice the quotient is what remains
      if (op == OP_DIVMOD) acc[s] = rm;
      acc[d] = r;
      pc = pc + 12'(by);
      for (int i = 0; i < 64 && !(nb > 0 && busy === 1'b0); i++) begin
         @(posedge clk_sys_in);
      end
      chk("cycles", 32'(nb), {24'h0, n});
      cmp_all();
   endtask

   initial begin
      repeat (20000) @(posedge clk_sys_in);
      n_mismatch++;
      print_verdict();
   end

   initial begin
      {n_mismatch, checked, nb, nw, ew, cfg, pc, ptr, fl} = '0;
      acc = '{default: '0};
      rst_n_in = 1'b0;
      repeat (12) @(posedge clk_sys_in);
      rst_n_in <= 1'b1;
      @(posedge clk_sys_in);
      chk("ready", {hresp, hrdy}, 32'h1);
      cmp_all();
      rd(8'h40, q);
      chk("unmapped", q, 32'h0);
      void'($urandom(93417));
      for (int i = 0; i < 4; i++) wa(i, 24'($urandom));
      wr(OFF_RAMPTR, 32'h5);
      ptr = 8'h5;
      for (int i = 0; i < 8; i++) begin
         run(i[0] ? OP_XNOR : OP_XOR, 2'($urandom), 2'($urandom), 5'h0, {2'b0, i[1]},
             24'($urandom));
      end
      run(OP_CMP, 2'd0, 2'd1, 5'h0, 3'h0, 24'h0);
      run(OP_CMP, 2'd2, 2'd0, 5'h0, 3'h1, 24'($urandom));
      run(OP_NEG, 2'd3, 2'd0, 5'h0, 3'h0, 24'h0);
      wa(1, 24'h0);
      run(OP_DECR, 2'd1, 2'd0, 5'h0, 3'h0, 24'h0);
      run(OP_DECPTR, 2'd0, 2'd0, 5'h0, 3'h0, 24'h0);
      run(OP_FLAGT, 2'd1, 2'd0, 5'h0, 3'h0, 24'h0);
      run(OP_CLRWDT, 2'd0, 2'd0, 5'h0, 3'h0, 24'h0);
      run(OP_CLRWDT, 2'd0, 2'd0, 5'h0, 3'h0, 24'h0);
      for (int i = 0; i < 10; i++) begin
         wa(2, 24'(i));
         run(OP_SEG, 2'd2, 2'd0, 5'h0, 3'h0, 24'h0);
      end
      wa(0, 24'h1);
      wa(1, 24'h4);
      run(OP_FDIV, 2'd0, 2'd1, 5'h0, 3'h4, 24'h0);
      wa(0, 24'hfffffd);
      wa(1, 24'h10);
      run(OP_FDIV, 2'd0, 2'd1, 5'h0, 3'h0, 24'h0);
      wa(2, 24'd100);
      wa(1, 24'd7);
      run(OP_DIVMOD, 2'd2, 2'd1, 5'h0, 3'h0, 24'h0);
      run(OP_CFGWR, 2'd0, 2'd0, 5'h0, 3'h0, 24'($urandom));
      wr(OFF_RAMPTR, 32'h0);
      ptr = 8'h0;
      run(OP_EERD, 2'd3, 2'd0, 5'h0, 3'h0, 24'h0);
      run(OP_JMP, 2'd0, 2'd0, 5'h0, 3'h0, 24'h80);
      run(OP_JMP, 2'd0, 2'd0, 5'h0, 3'h0, 24'h7f);
      run(OP_JMP, 2'd0, 2'd0, 5'h0, 3'h2, 24'($urandom));
      for (int i = 0; i < 8; i++) begin
         wa(0, i[0] ? 24'h800001 : 24'h7ffffe);
         run(i[1] ? OP_BITS : OP_BITC, 2'd0, 2'd0, i[2] ? 5'd23 : 5'd0, 3'h0,
             24'($urandom));
      end
      run(8'hff, 2'd0, 2'd0, 5'h0, 3'h0, 24'h0);
      rd(OFF_STATUS, q);
      chk("error", q & 32'h2, 32'h2);
      wr(OFF_STATUS, 32'h2);
      rd(OFF_STATUS, q);
      chk("error", q & 32'h2, 32'h0);
      chk("wdog", {24'h0, nw}, {24'h0, ew});
      print_verdict();
   end
endmodule // cpu_instruction_semantics_tb
`default_nettype wire
